/* File: quad_dtr_flash_read.sv */
// Purpose: Device-side sequencer for the quad double-rate read command.
// Assumes: sck, csN and lanes come from the pins; array read is combinational on readAddr.
// Notes: Both link clock edges are found by oversampling with ref_clk.
// Operation
// - Four bits per edge, eight per clock.
// - Start anywhere, address increments per byte.
// - Address rolls over to zero at top.
// - Command, address, eight dummy clocks, data.
// - Chip select rise stops output, ends command.
// - Mode bits 10 enter continuous read mode.
// - Other mode bits leave continuous read mode.
// - Reject read while write in progress.
// - Wrap setting applies to following reads.
// - Wrap within aligned section until deselect.
// - Three wrap bits: enable plus length.
// - Four-lane command takes two clocks.
// - Four-lane command ignores quad enable.
// - Four-lane mode otherwise behaves identically.
`timescale 1ns/1ns
module quad_dtr_flash_read (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic sck,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   output logic [23:0] readAddr,
   input wire logic [7:0] readData,
   input wire logic quadLaneEnableBit,
   input wire logic writeInProgressFlag,
   input wire logic fourLaneCommandMode,
   input wire logic [2:0] wrapSettingBits,
   output logic continuousReadActive,
   output logic commandRejected
);
   import quad_dtr_read_pkg::*;

   logic [5:0] syncA_q, syncA_d, syncB_q, syncB_d;
   logic sckPrev_q, sckPrev_d;
   logic csHigh, sckNow, sckRise, sckEdge;
   logic [3:0] lanes;
   seq_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [23:0] shift_q, shift_d;
   logic [23:0] addr_q, addr_d;
   logic [2:0] wrap_q, wrap_d;
   logic cont_q, cont_d;
   logic rej_q, rej_d;
   logic nibLow_q, nibLow_d;
   logic [3:0] out_q, out_d;
   logic [3:0] oe_q, oe_d;
   logic wrapOn;
   logic [23:0] wrapMask, addrInc, nextAddr;
   logic [23:0] cmdShift;
   logic [7:0] modeByte;
   logic [3:0] cmdLastEdge;

   // Two-stage synchronisers for csN, sck and the four lanes
   always_comb begin
      syncA_d = {csN, sck, ioIn};
      syncB_d = syncA_q;
      sckPrev_d = syncB_q[4];
   end

   // Reset to idle pin levels so that no false clock edge follows reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         syncA_q <= SYNC_RESET;
         syncB_q <= SYNC_RESET;
         sckPrev_q <= SCK_IDLE;
      end else begin
         syncA_q <= syncA_d;
         syncB_q <= syncB_d;
         sckPrev_q <= sckPrev_d;
      end
   end

   // Edge detection on the synchronised link clock
   assign csHigh = syncB_q[5];
   assign sckNow = syncB_q[4];
   assign lanes = syncB_q[3:0];
   assign sckRise = sckNow & ~sckPrev_q;
   assign sckEdge = sckNow ^ sckPrev_q;

   // Next byte address, wrapping inside an aligned section when enabled
   assign wrapOn = (wrap_q[WRAP_ENABLE_POS] == WRAP_ON_LEVEL);
   assign wrapMask = {16'h0000, (WRAP_BASE_LEN << wrap_q[2:1]) - 8'h01};
   assign addrInc = addr_q + 24'h000001;
   assign nextAddr = wrapOn ? ((addr_q & ~wrapMask) | (addrInc & wrapMask)) : addrInc;
   assign cmdShift = fourLaneCommandMode ? {shift_q[19:0], lanes} : {shift_q[22:0], lanes[0]};
   assign modeByte = {shift_q[3:0], lanes};
   assign cmdLastEdge = fourLaneCommandMode ? CMD_LAST_FOUR_LANE : CMD_LAST_ONE_LANE;

   // Command sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      addr_d = addr_q;
      wrap_d = wrap_q;
      cont_d = cont_q;
      rej_d = rej_q;
      nibLow_d = nibLow_q;
      out_d = out_q;
      oe_d = oe_q;
      if (csHigh) begin
         state_d = IDLE;
         oe_d = LANES_NONE;
         cnt_d = 4'h0;
      end else begin
         unique case (state_q)
            IDLE: begin
               wrap_d = wrapSettingBits;
               cnt_d = 4'h0;
               if (writeInProgressFlag) begin
                  state_d = IGNORE;
                  rej_d = 1'b1;
               end else begin
                  rej_d = 1'b0;
                  state_d = cont_q ? ADDR : CMD;
               end
            end
            CMD: begin
               if (sckRise) begin
                  shift_d = cmdShift;
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == cmdLastEdge) begin
                     cnt_d = 4'h0;
                     if (cmdShift[7:0] == CMD_QUAD_DTR_READ &&
                         (fourLaneCommandMode || quadLaneEnableBit)) begin
                        state_d = ADDR;
                     end else begin
                        state_d = IGNORE;
                     end
                  end
               end
            end
            ADDR: begin
               // Address opens on a rise; the last command clock's fall carries nothing
               if (sckEdge && (sckRise || cnt_q != 4'h0)) begin
                  shift_d = {shift_q[19:0], lanes};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == ADDR_LAST_EDGE) begin
                     addr_d = {shift_q[19:0], lanes};
                     cnt_d = 4'h0;
                     state_d = DUMMY;
                  end
               end
            end
            DUMMY: begin
               if (sckEdge) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q <= MODE_LAST_EDGE) begin
                     shift_d = {shift_q[19:0], lanes};
                  end
                  if (cnt_q == MODE_LAST_EDGE) begin
                     cont_d = (modeByte[5:4] == MODE_CONTINUE);
                  end
                  if (cnt_q == DUMMY_LAST_EDGE) begin
                     state_d = DATA;
                     oe_d = LANES_ALL;
                     out_d = readData[7:4];
                     nibLow_d = 1'b1;
                  end
               end
            end
            DATA: begin
               if (sckEdge) begin
                  if (nibLow_q) begin
                     out_d = readData[3:0];
                     nibLow_d = 1'b0;
                     addr_d = nextAddr;
                  end else begin
                     out_d = readData[7:4];
                     nibLow_d = 1'b1;
                  end
               end
            end
            IGNORE: begin
               oe_d = LANES_NONE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= IDLE;
         cnt_q <= 4'h0;
         shift_q <= ADDR_RESET;
         addr_q <= ADDR_RESET;
         wrap_q <= WRAP_RESET;
         cont_q <= 1'b0;
         rej_q <= 1'b0;
         nibLow_q <= 1'b0;
         out_q <= NIBBLE_RESET;
         oe_q <= LANES_NONE;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         addr_q <= addr_d;
         wrap_q <= wrap_d;
         cont_q <= cont_d;
         rej_q <= rej_d;
         nibLow_q <= nibLow_d;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   // Outputs straight from flops
   assign ioOut = out_q;
   assign ioOe = oe_q;
   assign readAddr = addr_q;
   assign continuousReadActive = cont_q;
   assign commandRejected = rej_q;

   // Checks
   chk_deselect_drive_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      csHigh |=> (oe_q == LANES_NONE && state_q == IDLE))
      else $error("Lanes still driven after deselect");

   chk_busy_reject_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == IDLE && !csHigh && writeInProgressFlag) |=> (state_q == IGNORE) [*2])
      else $error("Read not rejected while busy");

   chk_cont_skip_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == IDLE && !csHigh && !writeInProgressFlag && cont_q) |=> state_q == ADDR)
      else $error("Continuous mode did not skip command");

   chk_mode_byte_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == DUMMY && sckEdge && !csHigh && cnt_q == MODE_LAST_EDGE &&
       modeByte[5:4] != MODE_CONTINUE) |=> !cont_q)
      else $error("Continuous mode kept on wrong mode bits");

   chk_mode_byte_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == DUMMY && sckEdge && !csHigh && cnt_q == MODE_LAST_EDGE &&
       modeByte[5:4] == MODE_CONTINUE) |=> cont_q)
      else $error("Continuous mode not entered");

   chk_addr_step_plain: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == DATA && sckEdge && !csHigh && nibLow_q && !wrapOn)
      |=> addr_q == $past(addr_q) + 24'h000001)
      else $error("Address did not advance by one");

   chk_wrap_section_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == DATA && sckEdge && !csHigh && nibLow_q && wrapOn)
      |=> (addr_q & ~wrapMask) == ($past(addr_q) & ~wrapMask) && addr_q != $past(addr_q))
      else $error("Wrapped address left its section");

   chk_four_lane_accept: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == CMD && sckRise && !csHigh && fourLaneCommandMode &&
       cnt_q == CMD_LAST_FOUR_LANE && cmdShift[7:0] == CMD_QUAD_DTR_READ) |=> state_q == ADDR)
      else $error("Four-lane read not accepted");

   chk_addr_rise_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ADDR && sckEdge && !sckRise && !csHigh && cnt_q == 4'h0)
      |=> (state_q == ADDR && cnt_q == 4'h0))
      else $error("Address phase opened on a falling edge");

   chk_data_lanes_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == DATA && !csHigh) |-> oe_q == LANES_ALL)
      else $error("Data phase without all lanes driven");
endmodule

/* File: quad_dtr_read_pkg.sv */
// Purpose: Shared constants and types for the quad double-rate read sequencer.
// Assumes: Link signals are sampled by a 50 MHz core clock.
// Notes: Phase lengths are counted in link clock edges; the command phase counts rising edges only.
package quad_dtr_read_pkg;
   // Read opcode accepted by this sequencer
   localparam logic [7:0] CMD_QUAD_DTR_READ = 8'hed;
   // Last edge index of each phase (edges counted from zero)
   localparam logic [3:0] CMD_LAST_ONE_LANE = 4'h7;
   localparam logic [3:0] CMD_LAST_FOUR_LANE = 4'h1;
   localparam logic [3:0] ADDR_LAST_EDGE = 4'h5;
   localparam logic [3:0] MODE_LAST_EDGE = 4'h1;
   localparam logic [3:0] DUMMY_LAST_EDGE = 4'hf;
   // Mode byte bits five and four that keep continuous read
   localparam logic [1:0] MODE_CONTINUE = 2'b10;
   // Wrap section base length in bytes and enable polarity
   localparam logic [7:0] WRAP_BASE_LEN = 8'h08;
   localparam logic WRAP_ON_LEVEL = 1'b0;
   localparam int WRAP_ENABLE_POS = 0;
   // Reset values
   localparam logic [23:0] ADDR_RESET = 24'h000000;
   localparam logic [2:0] WRAP_RESET = 3'h1;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   // Synchroniser reset matches idle pins: csN high, sck low, lanes low
   localparam logic [5:0] SYNC_RESET = 6'h20;
   localparam logic SCK_IDLE = 1'b0;
   localparam logic [3:0] LANES_ALL = 4'hf;
   localparam logic [3:0] LANES_NONE = 4'h0;

   typedef enum logic [2:0] {
      IDLE, CMD, ADDR, DUMMY, DATA, IGNORE
   } seq_state_t;
endpackage

/* File: quad_dtr_host_model.sv */
// Purpose: Host controller model driving quad double-rate read frames.
// Assumes: Mode 0 link, sck low at chip select fall, 160 ns link period.
// Notes: Released lanes carry an inverting pattern, never the last value.
`timescale 1ns/1ns
module quad_dtr_host_model (
   output logic csN,
   output logic sck,
   output logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   logic [7:0] got [0:63];
   logic oeBad;

   // Idle link: deselected, clock low
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      ioIn = 4'h0;
      oeBad = 1'b0;
   end

   // Change lanes one core clock after the last edge, hold them through the next
   task automatic e(input logic [3:0] v);
      #20 ioIn = v;
      #60 sck = ~sck;
   endtask

   // One full frame; n bytes are sampled, then chip select rises in data phase
   task automatic frame(input bit cmd, input bit four, input logic [7:0] op,
         input logic [23:0] a, input logic [7:0] m, input int n);
      logic [7:0] b;
      oeBad = 1'b0;
      csN = 1'b0;
      if (cmd) begin
         for (int i = 0; i < (four ? 4 : 16); i++) begin
            e(four ? (i < 2 ? op[7:4] : op[3:0]) : {3'b000, op[7 - i / 2]});
         end
      end
      for (int i = 0; i < 6; i++) begin
         e(a[23 - 4 * i -: 4]);
      end
      e(m[7:4]);
      e(m[3:0]);
      for (int i = 0; i < 14; i++) begin
         e(~ioIn);
      end
      for (int i = 0; i < 2 * n; i++) begin
         #80;
         if (ioOe !== 4'hf) oeBad = 1'b1;
         b = {b[3:0], ioOut};
         if (i % 2 == 1) got[i / 2] = b;
         ioIn = ~ioIn;
         sck = ~sck;
      end
      csN = 1'b1;
      #100;
   endtask
endmodule

/* File: quad_dtr_flash_read_tb.sv */
// Purpose: Self-checking bench for the quad double-rate read sequencer.
// Assumes: Array model returns a fixed function of the byte address.
// Notes: Random frames with fixed seed plus rollover, continuous and refusal cases.
`timescale 1ns/1ns
module quad_dtr_flash_read_tb;
   import quad_dtr_read_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic csN, sck, contAct, rej;
   logic qe = 1'b1;
   logic write_in_progress_flag = 1'b0;
   logic four = 1'b0;
   int driveCnt = 0;
   logic [3:0] ioIn, ioOut, ioOe;
   logic [23:0] readAddr;
   logic [7:0] readData;
   logic [2:0] wrapBits = 3'h1;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [23:0] aRnd;
   logic [7:0] mRnd;
   int nRnd;

   function automatic logic [7:0] byteOf(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
   endfunction

   // Next byte address: aligned section when wrap is on, else 24-bit rollover
   function automatic logic [23:0] nextAddr(input logic [23:0] a, input logic [2:0] w);
      logic [23:0] m;
      m = (24'h000008 << w[2:1]) - 24'h000001;
      return (w[0] == WRAP_ON_LEVEL) ? ((a & ~m) | ((a + 24'h000001) & m)) : a + 24'h000001;
   endfunction

   assign readData = byteOf(readAddr);
   always #10 ref_clk = ~ref_clk;

   // Note any lane drive and cut a hang short
   always @(posedge ref_clk) begin
      if (ioOe !== 4'h0) driveCnt <= driveCnt + 1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         close_out();
      end
   end

   quad_dtr_host_model HOST (.csN(csN), .sck(sck), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

   quad_dtr_flash_read DUT (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .sck(sck),
      .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .readAddr(readAddr), .readData(readData),
      .quadLaneEnableBit(qe), .writeInProgressFlag(write_in_progress_flag), .fourLaneCommandMode(four),
      .wrapSettingBits(wrapBits), .continuousReadActive(contAct), .commandRejected(rej));

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Run one frame and, when drive is set, compare every sampled byte against the address walk
   task automatic rd(input bit cmd, input logic [7:0] op, input logic [23:0] a,
         input logic [7:0] m, input int n, input bit drive);
      logic [23:0] p;
      int d0;
      p = a;
      d0 = driveCnt;
      HOST.frame(cmd, four, op, a, m, n);
      chk("drive", 24'(drive), 24'(driveCnt != d0));
      chk("oeOff", 24'h0, 24'(ioOe));
      for (int i = 0; i < n && drive; i++) begin
         chk("data", 24'(byteOf(p)), 24'(HOST.got[i]));
         p = nextAddr(p, wrapBits);
      end
      if (drive) chk("oeData", 24'h0, 24'(HOST.oeBad));
   endtask

   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      void'($urandom(32'h197d));
      repeat (20) @(negedge ref_clk);
      chk("rstOe", 24'h0, 24'(ioOe));
      chk("rstAddr", 24'h0, readAddr);
      rst_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         four = 1'($urandom);
         wrapBits = 3'($urandom);
         qe = four ? 1'($urandom) : 1'b1;
         aRnd = 24'($urandom);
         mRnd = 8'($urandom) & 8'hcf;
         nRnd = 20 + int'($urandom % 30);
         rd(1'b1, CMD_QUAD_DTR_READ, aRnd, mRnd, nRnd, 1'b1);
      end
      wrapBits = 3'h1;
      rd(1'b1, CMD_QUAD_DTR_READ, 24'hfffffd, 8'h00, 6, 1'b1);
      rd(1'b1, CMD_QUAD_DTR_READ, 24'h01234f, 8'ha5, 3, 1'b1);
      chk("contOn", 24'h1, 24'(contAct));
      rd(1'b0, 8'h00, 24'h00abc0, 8'h00, 4, 1'b1);
      chk("contOff", 24'h0, 24'(contAct));
      four = 1'b1;
      rd(1'b1, CMD_QUAD_DTR_READ, 24'h000777, 8'h00, 3, 1'b1);
      write_in_progress_flag = 1'b1;
      rd(1'b1, CMD_QUAD_DTR_READ, 24'h000010, 8'h00, 2, 1'b0);
      chk("rejOn", 24'h1, 24'(rej));
      write_in_progress_flag = 1'b0;
      rd(1'b1, CMD_QUAD_DTR_READ, 24'h000020, 8'h00, 2, 1'b1);
      chk("rejOff", 24'h0, 24'(rej));
      rd(1'b1, 8'heb, 24'h000030, 8'h00, 2, 1'b0);
      four = 1'b0;
      qe = 1'b0;
      rd(1'b1, CMD_QUAD_DTR_READ, 24'h000040, 8'h00, 2, 1'b0);
      close_out();
   end
endmodule
